// >>> rtl/shcp_top.sv
`timescale 1ns/10ps
// Functional notes
// - Hibernate bit set turns off oscillator, PLL, buffer supply and card detect.
// - Clearing hibernate restores buffer supply, oscillator and PLL.
// - Misc bit 2 picks interrupt drive: 0 open-drain, 1 push-pull; resets 0.
// - Misc bit 1 resets 1; when 0 the DMA request output is held low.
// - Coma bit set loses all state; only software reset-all writes accepted.
// - Leaving coma restores power and performs a full device reset.
// - Hardware reset pin also brings the device out of coma.
// - PLL output equals input clock times feedback field plus one.
// - Feedback field resets to 4, multiplying by five.
// - PLL bit 15 resets 1 and bypasses PLL; PLL output equals oscillator.
// - PLL bit 14 resets 1, giving P of 1; else P from bits 6:5.
// - Post divider P alters only duty cycle, never the PLL frequency.
// - Base clock is PLL output over standard divisor times (N + M/16).
// - Waking from hibernate resets buffer FIFO pointers to empty.
// - In coma the data and interrupt pins are tri-stated, the DMA request is held low and card detection is off.
module shcp_top
  import shcp_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        rd_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [8:0]  std_divisor_i,
  input  wire logic        irq_req_i,
  input  wire logic        dma_req_i,
  output logic      [15:0] rdata_o,
  output logic             rdata_oe_o,
  output logic             int_n_o,
  output logic             int_oe_o,
  output logic             dma_request_line_o,
  output logic             osc_en_o,
  output logic             pll_en_o,
  output logic             buf_pwr_en_o,
  output logic             card_detect_en_o,
  output logic             core_pwr_en_o,
  output logic             fifo_ptr_rst_o,
  output logic             sw_reset_all_o,
  output logic      [5:0]  pll_mult_o,
  output logic      [2:0]  pll_post_div_o,
  output logic             base_clk_tick_o
);
  import shcp_pkg::*;

  logic [15:0] fdiv_reg, fdiv_next;
  logic [15:0] misc_reg, misc_next;
  logic [15:0] pll_reg, pll_next;
  shcp_mode_e  mode_reg, mode_next;
  logic        wr_seen_reg, wr_seen_next;
  logic [21:0] acc_reg, acc_next;
  logic [15:0] rdata_next;
  logic        rdata_oe_next, int_n_next, int_oe_next, dma_next;
  logic        osc_next, pll_en_next, buf_next, cd_next, core_next;
  logic        fifo_rst_next, swrst_next, tick_next;
  logic [5:0]  mult_next;
  logic [2:0]  post_next;
  logic        wr_take, rd_act, sra_write;
  logic [11:0] frac_div;
  logic [8:0]  std_div;
  logic [20:0] div_total;
  logic [21:0] acc_sum;

  // Bus decode: a write is taken once, on the first cycle of its strobe
  always_comb begin
    wr_take   = ~cs_n_i & ~wr_n_i & ~wr_seen_reg;
    rd_act    = ~cs_n_i & ~rd_n_i;
    sra_write = wr_take && addr_i == SWRST_OFFS && wdata_i[SWRST_ALL_BIT];
    wr_seen_next = ~cs_n_i & ~wr_n_i;
  end

  // Register file and power mode sequencing
  always_comb begin
    fdiv_next     = fdiv_reg;
    misc_next     = misc_reg;
    pll_next      = pll_reg;
    mode_next     = mode_reg;
    fifo_rst_next = 1'b0;
    swrst_next    = 1'b0;
    unique case (mode_reg)
      SHCP_COMA: begin
        // Everything else is dead; besides the hardware reset, the reset-all write is the only way back
        if (sra_write) begin
          fdiv_next     = FDIV_RST;
          misc_next     = MISC_RST;
          pll_next      = PLL_RST;
          mode_next     = SHCP_RUN;
          fifo_rst_next = 1'b1;
          swrst_next    = 1'b1;
        end
      end
      SHCP_RUN, SHCP_HIB: begin
        if (sra_write) begin
          fdiv_next     = FDIV_RST;
          misc_next     = MISC_RST;
          pll_next      = PLL_RST;
          swrst_next    = 1'b1;
          fifo_rst_next = 1'b1;
        end else if (wr_take) begin
          // Reserved bits are masked so they never store
          if (addr_i == FDIV_OFFS) begin
            fdiv_next = wdata_i & FDIV_WMASK;
          end
          if (addr_i == MISC_OFFS) begin
            misc_next = wdata_i & MISC_WMASK;
          end
          if (addr_i == PLL_OFFS) begin
            pll_next = wdata_i & PLL_WMASK;
          end
        end
        if (misc_next[MISC_COMA_BIT]) begin
          // State is lost: hold every field but the coma bit at its default while in coma
          mode_next = SHCP_COMA;
          fdiv_next = FDIV_RST;
          pll_next  = PLL_RST;
          misc_next = MISC_RST | (16'h0001 << MISC_COMA_BIT);
        end else if (misc_next[MISC_HIB_BIT]) begin
          mode_next = SHCP_HIB;
        end else begin
          mode_next = SHCP_RUN;
          // Buffer contents were lost with the supply, so restart empty
          if (mode_reg == SHCP_HIB) begin
            fifo_rst_next = 1'b1;
          end
        end
      end
    endcase
  end

  // Clock path: multiplier, post divider and fractional base-clock ticks
  always_comb begin
    if (pll_next[PLL_BYPASS_BIT]) begin
      mult_next = 6'h01;
    end else begin
      mult_next = {1'b0, pll_next[PLL_B_LSB +: 5]} + 6'h01;
    end
    // P only shapes the duty cycle; it is reported but never divides
    if (pll_next[PLL_DIRECT_BIT]) begin
      post_next = 3'h1;
    end else begin
      post_next = {1'b0, pll_next[PLL_P_LSB +: 2]};
    end
    // Divisor in sixteenths: 16N + M, read straight from the two fields
    frac_div = {fdiv_reg[FDIV_N_LSB +: 8], fdiv_reg[FDIV_M_LSB +: 4]};
    if (frac_div == 12'h000) begin
      frac_div = 12'h010; // Zero divisor would stall; treat as N = 1
    end
    std_div   = std_divisor_i == 9'h000 ? 9'h001 : std_divisor_i;
    div_total = std_div * frac_div;
    // Each clock adds the multiplier in sixteenths; a tick per divisor spent
    acc_sum   = acc_reg + 22'({mult_next, 4'h0});
    tick_next = 1'b0;
    acc_next  = acc_sum;
    if (mode_next != SHCP_RUN) begin
      acc_next = 22'h00_0000;
    end else if (acc_sum >= {1'b0, div_total}) begin
      tick_next = 1'b1;
      acc_next  = acc_sum - {1'b0, div_total};
      // Above the system clock rate the tick saturates at one per cycle
      if (acc_next >= {1'b0, div_total}) begin
        acc_next = 22'h00_0000;
      end
    end
  end

  // Pin and power outputs; read data and its enable come from the current state, the rest from next state
  always_comb begin
    osc_next    = mode_next == SHCP_RUN;
    pll_en_next = mode_next == SHCP_RUN && !pll_next[PLL_BYPASS_BIT];
    buf_next    = mode_next == SHCP_RUN;
    cd_next     = mode_next == SHCP_RUN;
    core_next   = mode_next != SHCP_COMA;
    dma_next    = misc_next[MISC_DMA_EN_BIT] && dma_req_i && mode_next != SHCP_COMA;
    if (mode_next == SHCP_COMA) begin
      int_oe_next = 1'b0;
      int_n_next  = 1'b1;
    end else if (misc_next[MISC_INT_PP_BIT]) begin
      int_oe_next = 1'b1;
      int_n_next  = ~irq_req_i;
    end else begin
      // Open drain: only pull low, the board resistor provides the high
      int_oe_next = irq_req_i;
      int_n_next  = 1'b0;
    end
    rdata_oe_next = rd_act && mode_reg != SHCP_COMA &&
                    (addr_i == FDIV_OFFS || addr_i == MISC_OFFS || addr_i == PLL_OFFS);
    rdata_next = 16'h0000;
    if (rdata_oe_next) begin
      if (addr_i == FDIV_OFFS) begin
        rdata_next = fdiv_reg;
      end
      if (addr_i == MISC_OFFS) begin
        rdata_next = misc_reg;
      end
      if (addr_i == PLL_OFFS) begin
        rdata_next = pll_reg;
      end
    end
  end

  // State registers; the hardware reset also ends coma
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fdiv_reg           <= FDIV_RST;
      misc_reg           <= MISC_RST;
      pll_reg            <= PLL_RST;
      mode_reg           <= SHCP_RUN;
      wr_seen_reg        <= 1'b0;
      acc_reg            <= 22'h00_0000;
      rdata_o            <= 16'h0000;
      rdata_oe_o         <= 1'b0;
      int_n_o            <= 1'b1;
      int_oe_o           <= 1'b0;
      dma_request_line_o <= 1'b0;
      osc_en_o           <= 1'b1;
      pll_en_o           <= 1'b0;
      buf_pwr_en_o       <= 1'b1;
      card_detect_en_o   <= 1'b1;
      core_pwr_en_o      <= 1'b1;
      fifo_ptr_rst_o     <= 1'b1;
      sw_reset_all_o     <= 1'b0;
      pll_mult_o         <= 6'h01;
      pll_post_div_o     <= 3'h1;
      base_clk_tick_o    <= 1'b0;
    end else begin
      fdiv_reg           <= fdiv_next;
      misc_reg           <= misc_next;
      pll_reg            <= pll_next;
      mode_reg           <= mode_next;
      wr_seen_reg        <= wr_seen_next;
      acc_reg            <= acc_next;
      rdata_o            <= rdata_next;
      rdata_oe_o         <= rdata_oe_next;
      int_n_o            <= int_n_next;
      int_oe_o           <= int_oe_next;
      dma_request_line_o <= dma_next;
      osc_en_o           <= osc_next;
      pll_en_o           <= pll_en_next;
      buf_pwr_en_o       <= buf_next;
      card_detect_en_o   <= cd_next;
      core_pwr_en_o      <= core_next;
      fifo_ptr_rst_o     <= fifo_rst_next;
      sw_reset_all_o     <= swrst_next;
      pll_mult_o         <= mult_next;
      pll_post_div_o     <= post_next;
      base_clk_tick_o    <= tick_next;
    end
  end

  // Checks
  AST_HIB_OFF: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg == SHCP_HIB |-> !osc_en_o && !pll_en_o && !buf_pwr_en_o && !card_detect_en_o)
    else $error("hibernate left a supply or detect enabled");
  AST_HIB_WAKE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $past(mode_reg) == SHCP_HIB && mode_reg == SHCP_RUN |-> fifo_ptr_rst_o && osc_en_o && buf_pwr_en_o)
    else $error("hibernate wake without pointer reset or power");
  AST_INT_DRIVE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg != SHCP_COMA && misc_reg[MISC_INT_PP_BIT] |-> int_oe_o)
    else $error("push-pull interrupt not driven");
  AST_INT_OD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !misc_reg[MISC_INT_PP_BIT] && int_oe_o |-> !int_n_o)
    else $error("open-drain interrupt drove high");
  AST_DMA_GATE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !misc_reg[MISC_DMA_EN_BIT] |-> !dma_request_line_o)
    else $error("dma request leaked while disabled");
  AST_COMA_REFUSE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg == SHCP_COMA && !sra_write |=> mode_reg == SHCP_COMA && pll_reg == PLL_RST)
    else $error("coma accepted an access other than reset-all");
  AST_COMA_EXIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg == SHCP_COMA && sra_write |=> mode_reg == SHCP_RUN && misc_reg == MISC_RST && sw_reset_all_o)
    else $error("coma exit did not fully reset");
  AST_COMA_TRI: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg == SHCP_COMA |-> !rdata_oe_o && !int_oe_o && !dma_request_line_o && !card_detect_en_o)
    else $error("pin driven during coma");
  AST_MULT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pll_mult_o == (pll_reg[PLL_BYPASS_BIT] ? 6'h01 : {1'b0, pll_reg[PLL_B_LSB +: 5]} + 6'h01))
    else $error("pll multiplier mismatch");
  AST_DEFAULTS: assert property (@(posedge clock_i)
    $rose(rst_n_i) |-> pll_reg == PLL_RST && misc_reg == MISC_RST && pll_mult_o == 6'h01)
    else $error("defaults wrong after reset");
  AST_RSV: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (misc_reg & ~MISC_WMASK) == 16'h0000 && (pll_reg & ~PLL_WMASK) == 16'h0000)
    else $error("reserved bit stored");
  AST_TICK_STOP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg != SHCP_RUN |-> !base_clk_tick_o)
    else $error("base clock ticked while powered down");
  AST_RUN_POWER: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg == SHCP_RUN |-> osc_en_o && buf_pwr_en_o && card_detect_en_o)
    else $error("run mode without oscillator, buffer supply or detect");
  AST_POST_DIRECT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pll_reg[PLL_DIRECT_BIT] |-> pll_post_div_o == 3'h1)
    else $error("direct mode did not force post divider to one");
  AST_FDIV_RSV: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (fdiv_reg & ~FDIV_WMASK) == 16'h0000)
    else $error("reserved divider bit stored");
endmodule // shcp_top

// >>> rtl/shcp_pkg.sv
package shcp_pkg;
  // Register byte offsets on the 16-bit host bus
  localparam logic [7:0]  FDIV_OFFS       = 8'hf6;
  localparam logic [7:0]  MISC_OFFS       = 8'hf8;
  localparam logic [7:0]  PLL_OFFS        = 8'hfa;
  localparam logic [7:0]  SWRST_OFFS      = 8'h2e;
  localparam int          SWRST_ALL_BIT   = 8;
  // Power mode and pin control fields
  localparam int          MISC_COMA_BIT   = 0;
  localparam int          MISC_DMA_EN_BIT = 1;
  localparam int          MISC_INT_PP_BIT = 2;
  localparam int          MISC_HIB_BIT    = 3;
  // Fractional divider fields
  localparam int          FDIV_N_LSB      = 0;
  localparam int          FDIV_M_LSB      = 8;
  // PLL fields
  localparam int          PLL_B_LSB       = 0;
  localparam int          PLL_P_LSB       = 5;
  localparam int          PLL_DIRECT_BIT  = 14;
  localparam int          PLL_BYPASS_BIT  = 15;
  // Writable bit masks; everything else is reserved and reads zero
  localparam logic [15:0] FDIV_WMASK      = 16'h0fff;
  localparam logic [15:0] MISC_WMASK      = 16'h000f;
  localparam logic [15:0] PLL_WMASK       = 16'hc07f;
  // Reset values
  localparam logic [15:0] FDIV_RST        = 16'h0001;
  localparam logic [15:0] MISC_RST        = 16'h0002;
  localparam logic [15:0] PLL_RST         = 16'hc024;
  // Fraction resolution of the divider, in sixteenths
  localparam int          FRAC_SHIFT      = 4;
  // Power modes
  typedef enum logic [2:0] {
    SHCP_RUN  = 3'b001,
    SHCP_HIB  = 3'b010,
    SHCP_COMA = 3'b100
  } shcp_mode_e;
endpackage

// >>> bench/shcp_host_model.sv
`timescale 1ns/10ps
// Host processor on the asynchronous memory bus
module shcp_host_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rdata_oe_i,
  output logic             cs_n_o,
  output logic             wr_n_o,
  output logic             rd_n_o,
  output logic      [7:0]  addr_o,
  output logic      [15:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end
  // Write held two edges, then released; the next access starts an edge later
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clock_i);
    @(posedge clock_i);
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    addr_o <= ~a; // Released lines never keep the old value
    wdata_o <= ~d;
  endtask
  // Read answer taken at the edge where the strobes are released
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic oe);
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    addr_o <= a;
    @(posedge clock_i);
    @(posedge clock_i);
    d = rdata_i;
    oe = rdata_oe_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    addr_o <= ~a;
  endtask
endmodule // shcp_host_model

// >>> bench/tb_sd_host_clock_and_power_control.sv
`timescale 1ns/10ps
module tb_sd_host_clock_and_power_control;
  import shcp_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cs_n, wr_n, rd_n, irq, dma_request_line, oe_s, rdoe, int_n, int_oe, dma;
  logic        osc, pll_en, bufp, cd, core, fifo, swr, tick;
  logic [7:0]  addr;
  logic [8:0]  sdiv = 9'h001;
  logic [15:0] wdata, rdata, d_s;
  logic [5:0]  mult;
  logic [2:0]  post;
  int          failures = 0;
  int          n_checks = 0;
  int          n_fifo = 0, n_swr = 0, n_tick = 0, n0;
  initial irq = 1'b0;
  initial dma_request_line = 1'b0;
  // 20 MHz clock
  always #25 clock_i = ~clock_i;
  shcp_host_model HOST (.clock_i(clock_i), .rdata_i(rdata), .rdata_oe_i(rdoe),
                        .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
                        .addr_o(addr), .wdata_o(wdata));
  shcp_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .addr_i(addr), .wdata_i(wdata), .std_divisor_i(sdiv), .irq_req_i(irq), .dma_req_i(dma_request_line),
    .rdata_o(rdata), .rdata_oe_o(rdoe), .int_n_o(int_n), .int_oe_o(int_oe), .dma_request_line_o(dma),
    .osc_en_o(osc), .pll_en_o(pll_en), .buf_pwr_en_o(bufp), .card_detect_en_o(cd), .core_pwr_en_o(core),
    .fifo_ptr_rst_o(fifo), .sw_reset_all_o(swr), .pll_mult_o(mult), .pll_post_div_o(post),
    .base_clk_tick_o(tick));
  // Pulse counters; single-cycle pulses would be missed inside bus tasks
  always @(posedge clock_i) begin
    if (fifo === 1'b1) n_fifo++;
    if (swr === 1'b1) n_swr++;
    if (tick === 1'b1) n_tick++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    HOST.rd(a, d_s, oe_s);
    chk(d_s, exp);
    chk(oe_s, 16'h0001);
  endtask
  task automatic stop_test;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    rchk(FDIV_OFFS, 16'h0001);
    rchk(MISC_OFFS, 16'h0002);
    rchk(PLL_OFFS, 16'hc024);
    chk(mult, 16'h0001);
    chk(post, 16'h0001);
    chk(pll_en, 16'h0000);
    chk(int_oe, 16'h0000);
  endtask
  task automatic t_pll;
    HOST.wr(PLL_OFFS, 16'hffff);
    rchk(PLL_OFFS, 16'hc07f);
    chk(mult, 16'h0001);
    HOST.wr(PLL_OFFS, 16'h0041);
    chk(mult, 16'h0002);
    chk(post, 16'h0002);
    chk(pll_en, 16'h0001);
    HOST.wr(PLL_OFFS, 16'h4041);
    chk(post, 16'h0001);
    chk(mult, 16'h0002);
    HOST.wr(PLL_OFFS, 16'h0003);
    chk(mult, 16'h0004);
  endtask
  task automatic t_misc;
    dma_request_line <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(dma, 16'h0001);
    HOST.wr(MISC_OFFS, 16'h0000);
    chk(dma, 16'h0000);
    irq <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk({int_oe, int_n}, 16'h0002);
    irq <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(int_oe, 16'h0000);
    HOST.wr(MISC_OFFS, 16'hfff6);
    rchk(MISC_OFFS, 16'h0006);
    chk({int_oe, int_n, dma}, 16'h0007);
  endtask
  task automatic t_hib;
    HOST.wr(MISC_OFFS, 16'h000e);
    chk({osc, pll_en, bufp, cd}, 16'h0000);
    n0 = n_fifo;
    HOST.wr(MISC_OFFS, 16'h0006);
    repeat (2) @(posedge clock_i);
    chk({osc, pll_en, bufp}, 16'h0007);
    chk(16'(n_fifo - n0), 16'h0001);
  endtask
  task automatic t_coma;
    HOST.wr(MISC_OFFS, 16'h0007);
    chk({core, cd, int_oe}, 16'h0000);
    HOST.rd(MISC_OFFS, d_s, oe_s);
    chk(oe_s, 16'h0000);
    HOST.wr(MISC_OFFS, 16'h0006);
    chk(core, 16'h0000);
    n0 = n_swr;
    HOST.wr(SWRST_OFFS, 16'h0100);
    @(posedge clock_i);
    chk(16'(n_swr - n0), 16'h0001);
    chk(core, 16'h0001);
    rchk(MISC_OFFS, 16'h0002);
    rchk(PLL_OFFS, 16'hc024);
    HOST.wr(MISC_OFFS, 16'h0001);
    chk(core, 16'h0000);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk(core, 16'h0001);
    rchk(MISC_OFFS, 16'h0002);
  endtask
  // Adding 32 per cycle against 2*24 gives two ticks every three cycles; one tick of slack at the edges
  task automatic t_tick;
    sdiv <= 9'h002;
    HOST.wr(PLL_OFFS, 16'h0021);
    HOST.wr(FDIV_OFFS, 16'h0801);
    repeat (8) @(posedge clock_i);
    n0 = n_tick;
    repeat (96) @(posedge clock_i);
    chk(16'((n_tick - n0) >= 63 && (n_tick - n0) <= 65), 16'h0001);
  endtask
  // Hang guard
  initial begin
    #2_000_000;
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_pll();
    t_misc();
    t_hib();
    t_coma();
    t_tick();
    stop_test();
  end
endmodule // tb_sd_host_clock_and_power_control
